/* core/uarx_rx.sv */
// Asynchronous receive front end with start qualification, majority vote and address filter
//
// Chosen here: the register offsets and register access over Wishbone.
`include "uarx_consts.svh"

module uarx_rx import uarx_pkg::*; #(
  parameter int DIV_W = 12
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic RXD,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic WB_ACK_O,
  output logic [31:0] WB_DAT_O,
  output logic RX_COMPLETE
);

  generate
    if (DIV_W < 8 || DIV_W > 16) begin : g_bad_width
      $error("uarx_rx: DIV_W must be 8 to 16");
    end
  endgenerate

  // ==========================================
  // Decoding helpers
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    case (csz)
      3'h0: data_bits = 4'h5;
      3'h1: data_bits = 4'h6;
      3'h2: data_bits = 4'h7;
      `UARX_CSZ_NINE: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

  // ==========================================
  // Declarations
  logic filt_q, filt_d;
  logic dbl_q, dbl_d;
  logic en_q, en_d;
  logic par_q, par_d;
  logic [2:0] csz_q, csz_d;
  logic [DIV_W-1:0] baud_q, baud_d;
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  uarx_state_e state_q, state_d;
  uarx_samp_t cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] shift_q, shift_d;
  logic [2:0] vote_q, vote_d;
  logic last_q, last_d;
  logic done_q, done_d;
  logic [8:0] data_q, data_d;
  logic fe_q, fe_d;
  logic rxc_q, rxc_d;
  logic tick;
  logic req, bus_edge, wr, pop, commit, keep, type_bit, bit_v, in_vote, vote_end;
  uarx_samp_t spb, sf, samp_n;
  logic [2:0] vote_new;
  logic [3:0] dbits, nbits;
  logic [9:0] aligned;
  logic [8:0] dmask;
  logic [15:0] baud16;

  // ==========================================
  // Sample clock
  // divisor sixteen or eight
  assign spb = dbl_q ? `UARX_SPB_DBL : `UARX_SPB_NORM;
  assign sf = dbl_q ? `UARX_SF_DBL : `UARX_SF_NORM;

  uarx_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .clk(SYS_CLK),
    .rst_n(RSTN),
    .en(en_q),
    .divisor(baud_q),
    .tick(tick)
  );

  // ==========================================
  // Sample position and vote
  // sample number wraps per bit
  assign samp_n = (cnt_q >= spb) ? 5'h01 : cnt_q + 5'h01;
  assign in_vote = (samp_n >= sf) && (samp_n <= sf + 5'h02);
  assign vote_end = (samp_n == sf + 5'h02);
  assign vote_new = {vote_q[1:0], RXD};
  assign bit_v = maj3(vote_new);

  assign dbits = data_bits(csz_q);
  assign nbits = dbits + {3'h0, par_q};
  assign aligned = shift_q >> (`UARX_FRAME_MAX - nbits);
  assign dmask = 9'h1ff >> (4'h9 - dbits);
  // type from stop or ninth bit
  assign type_bit = (dbits == 4'h9) ? aligned[8] : bit_v;
  assign keep = !(filt_q && !type_bit);

  // ==========================================
  // Bit recovery state machine
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    shift_d = shift_q;
    vote_d = vote_q;
    last_d = last_q;
    done_d = done_q;
    commit = 1'b0;
    if (!en_q) begin
      state_d = UARX_IDLE;
      cnt_d = 5'h00;
      bit_d = 4'h0;
      done_d = 1'b0;
      last_d = 1'b0;
    end else if (tick) begin
      last_d = RXD;
      if (state_q != UARX_IDLE && in_vote) begin
        vote_d = vote_new;
      end
      case (state_q)
        UARX_IDLE: begin
          if (last_q && !RXD) begin
            state_d = UARX_START;
            cnt_d = 5'h01;
            vote_d = 3'h0;
          end
        end
        UARX_START: begin
          cnt_d = samp_n;
          if (vote_end) begin
            state_d = bit_v ? UARX_IDLE : UARX_DATA;
            bit_d = 4'h0;
          end
        end
        UARX_DATA: begin
          cnt_d = samp_n;
          if (vote_end) begin
            shift_d = {bit_v, shift_q[9:1]};
            if (bit_q == nbits - 4'h1) begin
              state_d = UARX_STOP;
            end else begin
              bit_d = bit_q + 4'h1;
            end
          end
        end
        UARX_STOP: begin
          cnt_d = samp_n;
          if (done_q) begin
            // Double speed holds off the next edge by one sample
            state_d = UARX_IDLE;
            done_d = 1'b0;
          end else if (vote_end) begin
            // only the first stop bit counts
            commit = 1'b1;
            if (dbl_q) begin
              done_d = 1'b1;
            end else begin
              state_d = UARX_IDLE;
            end
          end
        end
        default: begin
          state_d = UARX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      state_q <= UARX_IDLE;
      cnt_q <= 5'h00;
      bit_q <= 4'h0;
      shift_q <= 10'h000;
      vote_q <= 3'h0;
      last_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      vote_q <= vote_d;
      last_q <= last_d;
      done_q <= done_d;
    end
  end

  // ==========================================
  // Receive holding register
  always_comb begin
    data_d = data_q;
    fe_d = fe_q;
    rxc_d = rxc_q;
    if (!en_q) begin
      rxc_d = 1'b0;
      fe_d = 1'b0;
    end else if (commit && keep) begin
      data_d = aligned[8:0] & dmask;
      fe_d = !bit_v;
      rxc_d = 1'b1;
    end else if (pop) begin
      // New frame wins over a read in the same cycle
      rxc_d = 1'b0;
      // Error flag leaves together with its frame
      fe_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      data_q <= 9'h000;
      fe_q <= 1'b0;
      rxc_q <= 1'b0;
    end else begin
      data_q <= data_d;
      fe_q <= fe_d;
      rxc_q <= rxc_d;
    end
  end

  // ==========================================
  // Wishbone slave
  assign req = WB_CYC_I && WB_STB_I;
  // Accesses take effect on the edge that sees ack high
  assign bus_edge = req && ack_q;
  assign wr = bus_edge && WB_WE_I;
  assign pop = bus_edge && !WB_WE_I && (WB_ADR_I == `UARX_DATA_OFF);
  assign baud16 = 16'(baud_q);

  always_comb begin
    logic [15:0] b;
    b = baud16;
    filt_d = filt_q;
    dbl_d = dbl_q;
    en_d = en_q;
    par_d = par_q;
    csz_d = csz_q;
    ack_d = req && !ack_q;
    rdata_d = rdata_q;
    if (wr && WB_ADR_I == `UARX_CTRL_OFF && WB_SEL_I[0]) begin
      filt_d = WB_DAT_I[`UARX_CTRL_FILT_BIT];
      dbl_d = WB_DAT_I[`UARX_CTRL_DBL_BIT];
    end
    if (wr && WB_ADR_I == `UARX_CFG_OFF && WB_SEL_I[0]) begin
      en_d = WB_DAT_I[`UARX_CFG_EN_BIT];
      csz_d = WB_DAT_I[`UARX_CFG_CSZ_MSB:`UARX_CFG_CSZ_LSB];
      par_d = WB_DAT_I[`UARX_CFG_PAR_BIT];
    end
    if (wr && WB_ADR_I == `UARX_BAUD_OFF) begin
      if (WB_SEL_I[0]) begin
        b[7:0] = WB_DAT_I[7:0];
      end
      if (WB_SEL_I[1]) begin
        b[15:8] = WB_DAT_I[15:8];
      end
    end
    baud_d = b[DIV_W-1:0];
    if (req && !ack_q) begin
      rdata_d = 32'h0000_0000;
      case (WB_ADR_I)
        `UARX_CTRL_OFF: begin
          rdata_d[`UARX_CTRL_RXC_BIT] = rxc_q;
          rdata_d[`UARX_CTRL_FE_BIT] = fe_q;
          rdata_d[`UARX_CTRL_DBL_BIT] = dbl_q;
          rdata_d[`UARX_CTRL_FILT_BIT] = filt_q;
        end
        `UARX_CFG_OFF: begin
          rdata_d[`UARX_CFG_EN_BIT] = en_q;
          rdata_d[`UARX_CFG_CSZ_MSB:`UARX_CFG_CSZ_LSB] = csz_q;
          rdata_d[`UARX_CFG_PAR_BIT] = par_q;
        end
        `UARX_BAUD_OFF: rdata_d[15:0] = baud16;
        `UARX_DATA_OFF: rdata_d[8:0] = data_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      filt_q <= 1'b0;
      dbl_q <= 1'b0;
      en_q <= 1'b0;
      par_q <= 1'b0;
      csz_q <= `UARX_CSZ_RST;
      baud_q <= '0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      filt_q <= filt_d;
      dbl_q <= dbl_d;
      en_q <= en_d;
      par_q <= par_d;
      csz_q <= csz_d;
      baud_q <= baud_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdata_q;
  assign RX_COMPLETE = rxc_q;

  // ==========================================
  // Assertions
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  start_entry_a: assert property (en_q && state_q == UARX_IDLE && tick && last_q && !RXD
    |=> state_q == UARX_START && cnt_q == 5'h01) else $error("start not entered at sample one");
  start_reject_a: assert property (en_q && state_q == UARX_START && tick && vote_end && bit_v
    |=> state_q == UARX_IDLE) else $error("noisy start not rejected");
  bit_wrap_a: assert property (en_q && state_q != UARX_IDLE && tick && cnt_q == spb
    |=> cnt_q == 5'h01) else $error("sample count did not wrap");
  stop_norm_a: assert property (en_q && state_q == UARX_STOP && tick && vote_end && !dbl_q && !done_q
    |=> state_q == UARX_IDLE) else $error("no early idle after stop vote");
  frame_keep_a: assert property (en_q && commit && keep |=> rxc_q) else $error("kept frame not flagged");
  frame_err_a: assert property (en_q && commit && keep
    |=> fe_q == !$past(bit_v)) else $error("frame error mismatch");
  filter_drop_a: assert property (en_q && commit && !keep && !rxc_q
    |=> !rxc_q && $stable(data_q)) else $error("data frame passed filter");
  disable_a: assert property (!en_q |=> state_q == UARX_IDLE && !rxc_q && cnt_q == 5'h00)
    else $error("disable did not clear receiver");
  bus_ack_a: assert property (req && !ack_q |=> ack_q ##1 !ack_q) else $error("ack not one cycle");

  frame_kept_c: cover property (commit && keep);
  frame_drop_c: cover property (commit && !keep);
  start_noise_c: cover property (state_q == UARX_START && tick && vote_end && bit_v);
  frame_err_c: cover property (commit && keep && !bit_v);
endmodule

/* common/uarx_consts.svh */
// Register offsets, field positions, reset values and sampling counts of the receive front end
`ifndef UARX_CONSTS_SVH
`define UARX_CONSTS_SVH

// ==========================================
// Register byte addresses
`define UARX_CTRL_OFF 8'hc0
`define UARX_CFG_OFF 8'hc4
`define UARX_BAUD_OFF 8'hc8
`define UARX_DATA_OFF 8'hcc

// ==========================================
// Control and status fields
`define UARX_CTRL_FILT_BIT 0
`define UARX_CTRL_DBL_BIT 1
`define UARX_CTRL_FE_BIT 4
`define UARX_CTRL_RXC_BIT 7

// ==========================================
// Configuration fields and ninth data bit
`define UARX_CFG_EN_BIT 0
`define UARX_CFG_CSZ_LSB 1
`define UARX_CFG_CSZ_MSB 3
`define UARX_CFG_PAR_BIT 4
`define UARX_DATA_NINTH_BIT 8

// ==========================================
// Reset value and nine-bit size code
`define UARX_CSZ_RST 3'h3
`define UARX_CSZ_NINE 3'h7

// ==========================================
// Samples per bit, first voting sample and longest frame in bits
`define UARX_SPB_NORM 5'h10
`define UARX_SPB_DBL 5'h08
`define UARX_SF_NORM 5'h08
`define UARX_SF_DBL 5'h04
`define UARX_FRAME_MAX 4'ha

`endif

/* common/uarx_pkg.sv */
// Types shared by the receive front end
package uarx_pkg;
  typedef enum logic [1:0] {
    UARX_IDLE  = 2'b00,
    UARX_START = 2'b01,
    UARX_DATA  = 2'b10,
    UARX_STOP  = 2'b11
  } uarx_state_e;
  typedef logic [4:0] uarx_samp_t;
endpackage

/* core/uarx_tick_gen.sv */
// Oversampling tick generator: one pulse every divisor plus one system clocks
module uarx_tick_gen #(
  parameter int DIV_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick
);
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
      $error("uarx_tick_gen: DIV_W must be 1 to 16");
    end
  endgenerate

  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (!en) begin
      cnt_d = '0;
    end else if (cnt_q >= divisor) begin
      // Compare with >= so a shrinking divisor never strands the count
      cnt_d = '0;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

/* verif/uarx_tx_model.sv */
// Behavioural far-end serial transmitter driving the receive line
module uarx_tx_model (
  input wire logic clk,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Timing
  // exact nominal rate
  int per = 2;
  initial line = 1'b1;
  task automatic hold(input logic v, input int n);
    repeat (n * per) begin
      @(posedge clk);
      line <= v;
    end
  endtask
  // ==========================================
  // Frames
  // ninth bit is frame type
  task automatic send(input logic [8:0] d, input int nb, input logic par, input logic stp,
                      input int spb, input int stop_len, input int post);
    hold(1'b0, spb);
    for (int i = 0; i < nb; i++) begin
      hold(d[i], spb);
    end
    if (par) begin
      hold(^d, spb);
    end
    hold(stp, stop_len);
    hold(1'b1, post);
  endtask
  // Low just past the first judging sample, then idle
  task automatic spike(input int spb);
    hold(1'b0, spb / 2);
    hold(1'b1, spb * 2);
  endtask
endmodule

/* verif/tb_uarx_rx.sv */
// Self-checking bench of the receive front end
`include "uarx_consts.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_uarx_rx;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic RXD;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h00;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic WB_ACK_O;
  logic [31:0] WB_DAT_O;
  logic RX_COMPLETE;
  int n_mismatch = 0;
  int checked = 0;
  int cyc_n = 0;
  logic [31:0] exp_q[$];
  string nm_q[$];
  logic [31:0] e_v;
  string e_n;
  logic [8:0] d1;
  logic [8:0] d2;
  int nb;
  always #12.5 SYS_CLK = ~SYS_CLK;
  uarx_rx DUT (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .RXD(RXD), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .RX_COMPLETE(RX_COMPLETE));
  uarx_tx_model m (.clk(SYS_CLK), .line(RXD));
  // ==========================================
  // Closing
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Whole run needs about 7500 cycles
  always @(posedge SYS_CLK) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_mismatch++;
      finish_test();
    end
  end
  // ==========================================
  // Wishbone master
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_SEL_I <= 4'h3;
    WB_DAT_I <= d;
    // Only the cycle ceiling ends a wait for ack
    do begin
      @(posedge SYS_CLK);
    end while (WB_ACK_O !== 1'b1);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    nm_q.push_back($sformatf("read_%h", a));
    bus(1'b0, a, 32'h0);
  endtask
  // Read data is judged at the ack edge against the oldest note
  always @(posedge SYS_CLK) begin
    if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && exp_q.size() > 0) begin
      e_v = exp_q.pop_front();
      e_n = nm_q.pop_front();
      `CHK(e_n, e_v, WB_DAT_O)
    end
  end
  // ==========================================
  // Receive helpers
  task automatic wait_rxc(input logic e);
    for (int i = 0; i < 80; i++) begin
      if (RX_COMPLETE === 1'b1) begin
        break;
      end
      @(posedge SYS_CLK);
    end
    `CHK("rx_complete", e, RX_COMPLETE)
  endtask
  task automatic rx_chk(input logic [8:0] d, input int n, input logic [7:0] cb);
    wait_rxc(1'b1);
    rd(`UARX_CTRL_OFF, {24'h0, 8'h80 | cb});
    rd(`UARX_DATA_OFF, {23'h0, d & 9'((1 << n) - 1)});
    rd(`UARX_CTRL_OFF, {24'h0, cb & 8'h03});
  endtask
  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask
  // ==========================================
  // Tests
  initial begin
    void'($urandom(18040));
    repeat (3) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    `CHK("rx_complete_rst", 1'b0, RX_COMPLETE)
    rd(`UARX_CTRL_OFF, 32'h0);
    rd(`UARX_CFG_OFF, 32'h6);
    rd(`UARX_BAUD_OFF, 32'h0);
    rd(`UARX_DATA_OFF, 32'h0);
    wr(8'hd0, 32'hff);
    rd(8'hd0, 32'h0);
    wr(`UARX_BAUD_OFF, 32'h1);
    tdone("reset");
    for (int k = 0; k < 5; k++) begin
      nb = (k == 4) ? 9 : k + 5;
      wr(`UARX_CFG_OFF, 32'h1 | ((k == 4 ? 7 : k) << 1) | ((k & 1) << 4));
      // Receiver must see the idle line once before a start edge counts
      repeat (4) @(posedge SYS_CLK);
      d1 = 9'($urandom);
      m.send(d1, nb, k[0], 1'b1, 16, 16, 4);
      rx_chk(d1, nb, 8'h00);
    end
    tdone("sizes");
    wr(`UARX_CFG_OFF, 32'h7);
    d1 = 9'($urandom);
    m.send(d1, 8, 1'b0, 1'b0, 16, 16, 4);
    rx_chk(d1, 8, 8'h10);
    d1 = 9'($urandom);
    d2 = 9'($urandom);
    m.send(d1, 8, 1'b0, 1'b1, 16, 10, 0);
    m.send(d2, 8, 1'b0, 1'b1, 16, 16, 4);
    rx_chk(d2, 8, 8'h00);
    wr(`UARX_CTRL_OFF, 32'h2);
    m.send(d1, 8, 1'b0, 1'b1, 8, 7, 0);
    m.send(d2, 8, 1'b0, 1'b1, 8, 8, 4);
    rx_chk(d2, 8, 8'h02);
    wr(`UARX_CTRL_OFF, 32'h0);
    tdone("timing");
    m.spike(16);
    wait_rxc(1'b0);
    m.send(d1, 8, 1'b0, 1'b1, 16, 16, 4);
    rx_chk(d1, 8, 8'h00);
    tdone("noise");
    wr(`UARX_CFG_OFF, 32'hf);
    wr(`UARX_CTRL_OFF, 32'h1);
    m.send(d1 & 9'h0ff, 9, 1'b0, 1'b1, 16, 16, 4);
    wait_rxc(1'b0);
    m.send(d2 | 9'h100, 9, 1'b0, 1'b1, 16, 16, 4);
    rx_chk(d2 | 9'h100, 9, 8'h01);
    wr(`UARX_CTRL_OFF, 32'h0);
    m.send(d1 & 9'h0ff, 9, 1'b0, 1'b1, 16, 16, 4);
    rx_chk(d1 & 9'h0ff, 9, 8'h00);
    wr(`UARX_CTRL_OFF, 32'h1);
    m.send(d2 & 9'h0ff, 9, 1'b0, 1'b1, 16, 16, 4);
    wait_rxc(1'b0);
    wr(`UARX_CFG_OFF, 32'h7);
    m.send(d1, 8, 1'b0, 1'b0, 16, 16, 4);
    wait_rxc(1'b0);
    m.send(d2, 8, 1'b0, 1'b1, 16, 16, 4);
    rx_chk(d2, 8, 8'h01);
    wr(`UARX_CTRL_OFF, 32'h0);
    tdone("filter");
    m.send(d1, 8, 1'b0, 1'b1, 16, 16, 4);
    wait_rxc(1'b1);
    wr(`UARX_CFG_OFF, 32'h6);
    // Enable drops at the ack edge, the flag one clock later
    repeat (2) @(posedge SYS_CLK);
    `CHK("rx_complete_flush", 1'b0, RX_COMPLETE)
    wr(`UARX_CFG_OFF, 32'h7);
    repeat (4) @(posedge SYS_CLK);
    fork
      m.send(d2, 8, 1'b0, 1'b1, 16, 16, 4);
      begin
        repeat (120) @(posedge SYS_CLK);
        wr(`UARX_CFG_OFF, 32'h6);
      end
    join
    wr(`UARX_CFG_OFF, 32'h7);
    wait_rxc(1'b0);
    rd(`UARX_CTRL_OFF, 32'h0);
    m.send(d1, 8, 1'b0, 1'b1, 16, 16, 4);
    rx_chk(d1, 8, 8'h00);
    tdone("disable");
    // Let the read checker take the last note before closing
    repeat (2) @(posedge SYS_CLK);
    `CHK("notes_left", 0, exp_q.size())
    finish_test();
  end
endmodule
